// file: hw/wdt_pkg.sv
// Function
// R1: Time-out with interrupt enabled sets the interrupt flag.
// R2: Executing the watchdog vector clears the interrupt flag.
// R3: Writing one to the flag position clears it; zero leaves it.
// R4: Interrupt request needs flag, enable and core global enable all set.
// R5: Reset-enable and interrupt-enable pair select stop, irq, reset, both.
// R6: Programmed fuse (0) forces reset mode regardless of the bits.
// R7: Combined mode: first time-out sets flag; vector clears enable and flag.
// R8: Combined mode: second time-out without vector gives system reset.
// R9: Software re-arms interrupt enable after each interrupt, outside the ISR.
// R10: Clearing reset-enable or changing prescaler needs change-enable set.
// R11: Change-enable clears itself four core cycles after being written one.
// R12: Reset-enable held at one while the watchdog reset flag is set.
// R13: Time-out is 2048 oscillator cycles shifted left by code 0..9.
// R14: Prescaler bits: bit 5 is the top bit, bits 2:0 the lower bits.
// R15: Change starts with change-enable and reset-enable written in one go.
// R16: Counter advances on the oscillator tick; restart clears it.
// R17: Programmed fuse locks reset-enable at one, interrupt-enable at zero.
// R18: Stopped mode keeps the counter cleared.
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR = 8'h60;
  localparam logic [7:0] STAT_ADDR = 8'h64;
  localparam logic [7:0] MASK_ADDR = 8'h68;

  // Control field positions
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int PRE_HI_BIT = 5;
  localparam int CHG_EN_BIT = 4;
  localparam int RST_EN_BIT = 3;

  // Event status bit positions
  localparam int EV_IRQ_BIT = 0;
  localparam int EV_RST_BIT = 1;
  localparam int EV_W = 2;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

  // Timing
  localparam int CHG_WINDOW_CYC = 4;
  localparam int BASE_TIMEOUT = 2048;
  localparam logic [3:0] MAX_PRESCALE = 4'h9;
  localparam int CORE_CLK_HZ = 250000000;
  localparam int OSC_HZ = 128000;
  localparam int OSC_DIV_CYC = CORE_CLK_HZ / OSC_HZ;

  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_IRQ,
    MODE_RESET,
    MODE_BOTH
  } wdt_mode_e;

endpackage

// file: hw/wdt_tick_gen.sv
`timescale 1ns/1ps
// Oscillator-rate enable pulse derived from the core clock
module wdt_tick_gen #(
  parameter int DIV = 1953
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Sync reset
  output logic tick_o // One-cycle oscillator tick
);

  logic [15:0] cnt_reg;
  logic [15:0] last_val;

  assign last_val = 16'(DIV - 1);

  // Free-running divider, pulse on wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_reg == last_val) begin
      cnt_reg <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule

// file: hw/wdt_ctrl.sv
`timescale 1ns/1ps
// Watchdog timer with control/status register on a Wishbone slave
module wdt_ctrl #(
  parameter int OSC_DIV = wdt_pkg::OSC_DIV_CYC,
  parameter int BASE_CYC = wdt_pkg::BASE_TIMEOUT
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic wb_err_o, // Unmapped address
  input wire logic restart_i, // Restart instruction pulse
  input wire logic vector_ack_i, // Core executes watchdog vector
  input wire logic global_irq_en_i, // Core global interrupt enable
  input wire logic always_on_fuse_i, // Fuse, 0 means programmed
  input wire logic watchdog_reset_flag_i, // Reset-cause flag
  output logic timeout_irq_o, // Vector request to the core
  output logic system_reset_o, // Watchdog system reset pulse
  output logic irq_o // Masked event interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the fuse and reset flag
  logic fuse_s1_reg;
  logic fuse_s2_reg;
  logic rflag_s1_reg;
  logic rflag_s2_reg;

  // Two-stage synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_s1_reg <= 1'b1;
      fuse_s2_reg <= 1'b1;
      rflag_s1_reg <= 1'b0;
      rflag_s2_reg <= 1'b0;
    end else begin
      fuse_s1_reg <= always_on_fuse_i;
      fuse_s2_reg <= fuse_s1_reg;
      rflag_s1_reg <= watchdog_reset_flag_i;
      rflag_s2_reg <= rflag_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic timeout_irq_flag_reg;
  logic timeout_irq_enable_reg;
  logic change_enable_reg;
  logic system_reset_enable_reg;
  logic [3:0] timeout_prescale_select_reg;
  logic [2:0] chg_cnt_reg;
  logic [wdt_pkg::EV_W-1:0] ev_status_reg;
  logic [wdt_pkg::EV_W-1:0] ev_mask_reg;
  logic [20:0] wdt_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire sel_ctrl = (wb_adr_i == wdt_pkg::CTRL_ADDR);
  wire sel_stat = (wb_adr_i == wdt_pkg::STAT_ADDR);
  wire sel_mask = (wb_adr_i == wdt_pkg::MASK_ADDR);
  wire mapped = sel_ctrl | sel_stat | sel_mask;
  wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr_lane0 & sel_ctrl;
  wire wr_stat = wr_lane0 & sel_stat;
  wire wr_mask = wr_lane0 & sel_mask;
  wire [7:0] wd = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Effective configuration
  wire fuse_prog = ~fuse_s2_reg; // R6
  wire rflag = rflag_s2_reg;
  wire eff_rst_en = system_reset_enable_reg | fuse_prog | rflag; // R12 R17
  wire eff_irq_en = timeout_irq_enable_reg & ~fuse_prog; // R17
  wire [3:0] eff_pre = (timeout_prescale_select_reg > wdt_pkg::MAX_PRESCALE)
                       ? wdt_pkg::MAX_PRESCALE
                       : timeout_prescale_select_reg;

  // Mode select from the enable pair
  wdt_pkg::wdt_mode_e mode;
  assign mode = wdt_pkg::wdt_mode_e'({eff_rst_en, eff_irq_en}); // R5 R6

  ////////////////////////////////////////////////////////////////////////////
  // Time-out length: base shifted by the prescale code
  function automatic logic [20:0] timeout_len(input logic [3:0] code);
    timeout_len = 21'(BASE_CYC) << code; // R13
  endfunction

  logic osc_tick;

  wdt_tick_gen #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(osc_tick)
  );

  wire running = (mode != wdt_pkg::MODE_STOP);
  // Restart in the same cycle wins over a time-out
  wire timeout = running & osc_tick & ~restart_i // R16
                 & (wdt_cnt_reg >= timeout_len(eff_pre) - 21'h000001);

  // Time-out actions by mode
  wire to_irq = timeout & (mode == wdt_pkg::MODE_IRQ
                | (mode == wdt_pkg::MODE_BOTH & ~timeout_irq_flag_reg)); // R1 R7
  wire to_rst = timeout & (mode == wdt_pkg::MODE_RESET
                | (mode == wdt_pkg::MODE_BOTH & timeout_irq_flag_reg)); // R8

  // Watchdog counter on oscillator ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_cnt_reg <= 21'h000000;
    end else if (!running || restart_i || timeout) begin
      wdt_cnt_reg <= 21'h000000; // R16 R18
    end else if (osc_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + 21'h000001; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protected change window
  wire chg_open = change_enable_reg;
  wire prot_ok = chg_open & ~wd[wdt_pkg::CHG_EN_BIT]; // R10 R15
  wire [3:0] wr_pre = {wd[wdt_pkg::PRE_HI_BIT], wd[2:0]}; // R14

  // Change-enable set by a write with reset-enable, self-clears after 4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_enable_reg <= 1'b0;
      chg_cnt_reg <= 3'h0;
    end else if (wr_ctrl && wd[wdt_pkg::CHG_EN_BIT]
                 && wd[wdt_pkg::RST_EN_BIT]) begin
      change_enable_reg <= 1'b1; // R15
      chg_cnt_reg <= 3'(wdt_pkg::CHG_WINDOW_CYC);
    end else if (wr_ctrl && chg_open) begin
      change_enable_reg <= 1'b0;
      chg_cnt_reg <= 3'h0;
    end else if (chg_cnt_reg == 3'h1) begin
      change_enable_reg <= 1'b0; // R11
      chg_cnt_reg <= 3'h0;
    end else if (chg_cnt_reg != 3'h0) begin
      chg_cnt_reg <= chg_cnt_reg - 3'h1; // R11
    end
  end

  // Reset-enable and prescaler updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_reset_enable_reg <= 1'b0;
      timeout_prescale_select_reg <= 4'h0;
    end else if (wr_ctrl) begin
      if (wd[wdt_pkg::RST_EN_BIT]) begin
        system_reset_enable_reg <= 1'b1;
      end else if (prot_ok && !rflag) begin
        system_reset_enable_reg <= 1'b0; // R10 R12
      end
      if (prot_ok) begin
        timeout_prescale_select_reg <= wr_pre; // R10 R14
      end
    end
  end

  // Interrupt enable; vector in combined mode clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_irq_enable_reg <= 1'b0;
    end else if (vector_ack_i && mode == wdt_pkg::MODE_BOTH) begin
      timeout_irq_enable_reg <= 1'b0; // R7
    end else if (wr_ctrl) begin
      timeout_irq_enable_reg <= wd[wdt_pkg::IRQ_EN_BIT]; // R9
    end
  end

  // Interrupt flag: time-out sets, vector or write-one clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_irq_flag_reg <= 1'b0;
    end else if (to_irq) begin
      timeout_irq_flag_reg <= 1'b1; // R1
    end else if (vector_ack_i) begin
      timeout_irq_flag_reg <= 1'b0; // R2 R7
    end else if (wr_ctrl && wd[wdt_pkg::FLAG_BIT]) begin
      timeout_irq_flag_reg <= 1'b0; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and mask
  wire [wdt_pkg::EV_W-1:0] ev_set = {to_rst, to_irq};
  wire [wdt_pkg::EV_W-1:0] ev_clr = wr_stat ? wd[wdt_pkg::EV_W-1:0]
                                            : {wdt_pkg::EV_W{1'b0}};

  // Sticky events, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_status_reg <= {wdt_pkg::EV_W{1'b0}};
      ev_mask_reg <= wdt_pkg::MASK_RESET;
    end else begin
      ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
      if (wr_mask) begin
        ev_mask_reg <= wd[wdt_pkg::EV_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] ctrl_view = {timeout_irq_flag_reg, eff_irq_en,
                          timeout_prescale_select_reg[3], change_enable_reg,
                          eff_rst_en, timeout_prescale_select_reg[2:0]};
  wire [31:0] rd_data = sel_ctrl ? {24'h000000, ctrl_view}
                      : sel_stat ? {30'h00000000, ev_status_reg}
                      : sel_mask ? {30'h00000000, ev_mask_reg}
                      : 32'h00000000;

  // Bus answer and outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      timeout_irq_o <= 1'b0;
      system_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & mapped;
      wb_err_o <= bus_req & ~mapped;
      wb_dat_o <= (bus_req & mapped & ~wb_we_i) ? rd_data : 32'h00000000;
      timeout_irq_o <= timeout_irq_flag_reg & eff_irq_en
                       & global_irq_en_i & ~vector_ack_i; // R4
      system_reset_o <= to_rst; // R6 R8
      irq_o <= |(ev_status_reg & ev_mask_reg);
    end
  end

endmodule

// file: sim/wdt_ctrl_monitor.sv
`timescale 1ns/1ps
// Port checks of the watchdog block
module wdt_ctrl_monitor #(
  parameter int OSC_DIV = 1953,
  parameter int BASE_CYC = 2048
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic wb_err_o, // Error
  input wire logic restart_i, // Restart
  input wire logic vector_ack_i, // Vector
  input wire logic global_irq_en_i, // Global enable
  input wire logic always_on_fuse_i, // Fuse
  input wire logic timeout_irq_o, // Request
  input wire logic system_reset_o // Reset pulse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken and address decode
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire hit = wb_adr_i inside {wdt_pkg::CTRL_ADDR, wdt_pkg::STAT_ADDR,
    wdt_pkg::MASK_ADDR};
  ////////////////////////////////////////////////////////////////////////////
  a_ack_mapped: assert property (take && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (take && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_irq_global: assert property (timeout_irq_o |-> $past(global_irq_en_i))
    else $error("request without global enable");
  a_irq_gate_off: assert property (!global_irq_en_i |=> !timeout_irq_o)
    else $error("request stays after global off");
  a_vector_clear: assert property (vector_ack_i |-> ##2 !timeout_irq_o)
    else $error("vector left request up");
  a_reset_pulse: assert property (system_reset_o |=> !system_reset_o)
    else $error("reset pulse too long");
  a_restart_quiet: assert property (restart_i |=> !system_reset_o [*3])
    else $error("reset right after restart");
  a_fuse_lock: assert property (!always_on_fuse_i [*4] |=> !timeout_irq_o)
    else $error("request with fuse programmed");
endmodule

bind wdt_ctrl wdt_ctrl_monitor #(.OSC_DIV(OSC_DIV), .BASE_CYC(BASE_CYC)) mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .restart_i(restart_i), .vector_ack_i(vector_ack_i),
  .global_irq_en_i(global_irq_en_i), .always_on_fuse_i(always_on_fuse_i),
  .timeout_irq_o(timeout_irq_o), .system_reset_o(system_reset_o));

// file: sim/core_model.sv
`timescale 1ns/1ps
// Core side: takes the watchdog vector when allowed
module core_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic req_i, // Vector request
  input wire logic auto_i, // Take vectors
  output logic ack_o // Vector executed
);
  logic busy_reg;
  // One vector per request; never writes the enable back
  always_ff @(posedge clk_i) begin
    ack_o <= 1'h0;
    if (rst_i || !req_i) begin
      busy_reg <= 1'h0;
    end else if (auto_i && !busy_reg) begin
      ack_o <= 1'h1;
      busy_reg <= 1'h1;
    end
  end
endmodule

// file: sim/wdt_ctrl_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the watchdog block
module wdt_ctrl_tb_top;
  localparam logic [7:0] CA = wdt_pkg::CTRL_ADDR;
  localparam logic [7:0] SA = wdt_pkg::STAT_ADDR;
  localparam logic [7:0] MA = wdt_pkg::MASK_ADDR;
  localparam int OD = 2;
  localparam int BC = 4;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rs = 0;
  logic gie = 0, fuse = 1, rfl = 0, auto = 0, vec, ack, err, tirq, srst, irq;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  int err_total = 0, comparisons = 0, n;
  int cs[4] = '{0, 1, 9, 10};
  always #2 clk_i = ~clk_i;
  // Block and core model
  wdt_ctrl #(.OSC_DIV(OD), .BASE_CYC(BC)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .restart_i(rs),
    .vector_ack_i(vec), .global_irq_en_i(gie), .always_on_fuse_i(fuse),
    .watchdog_reset_flag_i(rfl), .timeout_irq_o(tirq),
    .system_reset_o(srst), .irq_o(irq));
  core_model CPU (.clk_i(clk_i), .rst_i(rst_i), .req_i(tirq),
    .auto_i(auto), .ack_o(vec));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // One classic cycle; error shows as bit 31
  task automatic bus(input logic w, input logic [7:0] a, d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && err !== 1'h1 && k < 50);
    if (k >= 50) begin
      err_total++;
      $display("unexpected bus answer exp ack got none");
    end
    q = rdat | {err, 31'h0};
    {cyc, stb} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'h1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string s);
    bus(1'h0, a, 8'h00);
    chk(s, e, q);
  endtask
  // Protected change: open, then write within the window
  task automatic setc(input logic [7:0] v);
    wr(CA, 8'h18);
    wr(CA, v);
  endtask
  function automatic logic [7:0] pb(input logic [3:0] c);
    return {2'h0, c[3], 2'h0, c[2:0]};
  endfunction
  function automatic logic [31:0] win(input int lo, hi);
    return {31'h0, n >= lo && n <= hi};
  endfunction
  task automatic wt(input bit r, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((r ? srst : tirq) !== 1'h1 && n < lim);
  endtask
  task automatic pulse_restart();
    rs <= 1'h1;
    @(posedge clk_i);
    rs <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_prot();
    rc(CA, 32'h00, "ctrl reset");
    rc(MA, 32'h00, "mask reset");
    rc(8'h70, 32'h8000_0000, "unmapped");
    wr(CA, 8'h08);
    wr(CA, 8'h00);
    rc(CA, 32'h08, "clear refused");
    wr(CA, 8'h18);
    repeat (6) @(posedge clk_i);
    rc(CA, 32'h08, "window closed");
    wr(CA, 8'h00);
    rc(CA, 32'h08, "late clear");
    setc(pb(9));
    rc(CA, 32'h21, "protected");
    rfl <= 1'h1;
    repeat (3) @(posedge clk_i);
    rc(CA, 32'h29, "flag holds");
    setc(pb(9));
    rc(CA, 32'h29, "flag blocks");
    rfl <= 1'h0;
    repeat (3) @(posedge clk_i);
    setc(pb(9));
    rc(CA, 32'h21, "flag gone");
    $display("t_prot done");
  endtask
  task automatic t_time();
    foreach (cs[i]) begin
      setc(8'h08 | pb(cs[i]));
      wt(1, 9000);
      wt(1, 9000);
      chk("period", OD * (BC << (cs[i] > 9 ? 9 : cs[i])), n);
    end
    setc(8'h09);
    wt(1, 100);
    repeat (8) @(posedge clk_i);
    pulse_restart();
    wt(1, 100);
    chk("restart", 1, win(12, 19));
    setc(pb(1));
    wt(1, 40);
    chk("stopped", 40, n);
    wr(CA, 8'h09);
    wt(1, 100);
    chk("fresh count", 1, win(12, 19));
    $display("t_time done");
  endtask
  task automatic t_irq();
    gie <= 1'h1;
    setc(8'h43);
    wt(0, 300);
    pulse_restart();
    chk("request", 1, tirq);
    rc(CA, 32'hC3, "flag set");
    gie <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk("gated", 0, tirq);
    gie <= 1'h1;
    wr(CA, 8'h43);
    rc(CA, 32'hC3, "zero kept");
    wr(CA, 8'hC3);
    rc(CA, 32'h43, "one clears");
    rc(SA, 32'h03, "status");
    chk("masked", 0, irq);
    wr(MA, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq on", 1, irq);
    wr(SA, 8'h01);
    rc(SA, 32'h02, "status clear");
    chk("irq off", 0, irq);
    auto <= 1'h1;
    wt(0, 300);
    repeat (4) @(posedge clk_i);
    chk("vector", 0, tirq);
    rc(CA, 32'h43, "vector flag");
    $display("t_irq done");
  endtask
  task automatic t_both();
    auto <= 1'h0;
    wr(CA, 8'h4B);
    wt(0, 300);
    wt(1, 300);
    chk("second timeout", 1, win(60, 68));
    auto <= 1'h1;
    wr(CA, 8'hCB);
    wt(0, 300);
    repeat (4) @(posedge clk_i);
    rc(CA, 32'h0B, "vector ends irq");
    wr(CA, 8'h4B);
    $display("t_both done");
  endtask
  task automatic t_fuse();
    fuse <= 1'h0;
    repeat (4) @(posedge clk_i);
    rc(CA, 32'h0B, "fuse lock");
    wt(1, 300);
    chk("fuse reset", 1, win(1, 70));
    setc(pb(3));
    rc(CA, 32'h0B, "fuse keeps");
    fuse <= 1'h1;
    // Mid-run reset clears the control register again
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rc(CA, 32'h00, "reset again");
    chk("no reset pulse", 0, srst);
    $display("t_fuse done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    t_prot();
    t_time();
    t_irq();
    t_both();
    t_fuse();
    conclude();
  end
  // Hang guard
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
